// ===== src/rirq_cfg.svh
`ifndef RIRQ_CFG_SVH
`define RIRQ_CFG_SVH

// Register offsets on the register port
`define RIRQ_OFS_FLAGS_A    8'h06
`define RIRQ_OFS_FLAGS_B    8'h07
`define RIRQ_OFS_ENABLE_A   8'h08
`define RIRQ_OFS_ENABLE_B   8'h09

// Shared bit positions
`define RIRQ_BIT_SELECT     7
`define RIRQ_BIT_COMBINED   6

// Flag group a
`define RIRQ_BIT_HI_ALERT   6
`define RIRQ_BIT_LO_ALERT   5
`define RIRQ_BIT_CMD_DONE   4
`define RIRQ_BIT_TX_DONE    3
`define RIRQ_BIT_RX_DONE    2
`define RIRQ_BIT_ERROR      1
`define RIRQ_BIT_FRAME      0

// Flag group b
`define RIRQ_BIT_CARD       5
`define RIRQ_BIT_TIMER_TOP  4

// Enable group a / b control bits
`define RIRQ_BIT_POL_INV    7
`define RIRQ_BIT_PUSH_PULL  7
`define RIRQ_BIT_PIN_GATE   6

// Reset values
`define RIRQ_RST_FLAGS_A    7'h00
`define RIRQ_RST_FLAGS_B    6'h00
`define RIRQ_RST_ENABLE_A   8'h00
`define RIRQ_RST_ENABLE_B   8'h00
`define RIRQ_RST_RDATA      8'h00

`endif

// ===== src/rirq_pin_drv.sv
module rirq_pin_drv (
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  rirq_pin_if.drv   ctl,
  output logic      pin_out_o,
  output logic      pin_oe_o
);
  logic level;
  logic pin_val;
  logic pin_out_nxt;
  logic pin_oe_nxt;
  logic pin_out_r;
  logic pin_oe_r;

  always_comb begin
    level   = ctl.req & ctl.gate;
    pin_val = level ^ ctl.invert;
    if (ctl.push_pull) begin
      pin_out_nxt = pin_val;
      pin_oe_nxt  = 1'b1;
    end else begin
      // Open drain only ever pulls low; the wire idles high externally
      pin_out_nxt = 1'b0;
      pin_oe_nxt  = ~pin_val;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_out_r <= 1'b0;
      pin_oe_r  <= 1'b0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
    end
  end

  assign pin_out_o = pin_out_r;
  assign pin_oe_o  = pin_oe_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_pin_gate_off: assert property (!ctl.gate && ctl.push_pull
                                   |=> pin_out_o == $past(ctl.invert))
    else $error("Pin shows a request while pin gate is off");
  a_pin_polarity: assert property (ctl.push_pull && ctl.gate && ctl.req
                                   |=> pin_out_o == !$past(ctl.invert))
    else $error("Pin polarity does not follow invert bit");
  a_drive_open: assert property (!ctl.push_pull
                                 |=> !pin_out_o && pin_oe_o ==
                                     (!($past(ctl.req) && $past(ctl.gate)) ^ $past(ctl.invert)))
    else $error("Open drain pin drives high or wrong level");
  a_drive_push: assert property (ctl.push_pull |=> pin_oe_o)
    else $error("Push pull pin not driven");
endmodule

// ===== src/rirq_pin_if.sv
interface rirq_pin_if;
  logic req;
  logic gate;
  logic invert;
  logic push_pull;

  modport src (output req, output gate, output invert, output push_pull);
  modport drv (input req, input gate, input invert, input push_pull);
endinterface

// ===== src/rirq_pkg.sv
package rirq_pkg;

  typedef logic [7:0] rirq_byte_t;
  typedef logic [6:0] rirq_flags_a_t;
  typedef logic [5:0] rirq_flags_b_t;

  typedef enum logic [2:0] {
    RIRQ_SEL_NONE,
    RIRQ_SEL_FLAGS_A,
    RIRQ_SEL_FLAGS_B,
    RIRQ_SEL_ENABLE_A,
    RIRQ_SEL_ENABLE_B
  } rirq_sel_t;

endpackage

// ===== src/rirq_top.sv
// Function
// - Writing the second flag register with bit 7 high sets each flag in bits 5..0 written one.
// - Writing the second flag register with bit 7 low clears each flag in bits 5..0 written as one.
// - Bit 6 of the second flag register shows the combined request of all enabled active flags.
// - The card-detect flag in bit 5 is set when low-power card detection finds a card.
// - Each of the five timer flags, bit n for timer n, is set when that timer underflows.
// - Bit 7 of the first enable register high inverts the interrupt pin polarity.
// - Bits 6..0 of the first enable register gate the matching group-a flags onto the request.
// - Bits 5..0 of the second enable register gate card-detect and timer flags onto the request.
// - Bit 7 of the second enable register selects push-pull drive, else open drain.
// - The request reaches the pin only while bit 6 of the second enable register is high.
// - The first flag register uses the same bit 7 set or clear scheme for its bits 6..0.
// - The command-done flag is set when a command ends by itself or an unknown one reverts.
// - The high and low alert flags latch on a rising level status and hold until cleared.
module rirq_top
  import rirq_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  input  wire logic       fifo_hi_level_i,
  input  wire logic       fifo_lo_level_i,
  input  wire logic       cmd_self_end_i,
  input  wire logic       cmd_unknown_i,
  input  wire logic       tx_done_i,
  input  wire logic       rx_end_i,
  input  wire logic       error_i,
  input  wire logic       frame_start_i,
  input  wire logic       card_found_i,
  input  wire logic [4:0] timer_underflow_i,
  output logic            irq_pin_o,
  output logic            irq_pin_oe_o
);
`include "rirq_cfg.svh"

  function automatic rirq_sel_t rirq_decode(input rirq_byte_t addr);
    rirq_sel_t sel;
    sel = RIRQ_SEL_NONE;
    if (addr == `RIRQ_OFS_FLAGS_A) begin
      sel = RIRQ_SEL_FLAGS_A;
    end else if (addr == `RIRQ_OFS_FLAGS_B) begin
      sel = RIRQ_SEL_FLAGS_B;
    end else if (addr == `RIRQ_OFS_ENABLE_A) begin
      sel = RIRQ_SEL_ENABLE_A;
    end else if (addr == `RIRQ_OFS_ENABLE_B) begin
      sel = RIRQ_SEL_ENABLE_B;
    end
    return sel;
  endfunction

  function automatic logic rirq_any_enabled(input rirq_flags_a_t fa, input rirq_flags_b_t fb,
                                            input rirq_byte_t ea, input rirq_byte_t eb);
    return (|(fa & ea[6:0])) | (|(fb & eb[5:0]));
  endfunction

  rirq_sel_t     wr_sel;
  rirq_sel_t     rd_sel;
  logic          sel_set;

  rirq_flags_a_t flags_a_r;
  rirq_flags_a_t flags_a_nxt;
  rirq_flags_b_t flags_b_r;
  rirq_flags_b_t flags_b_nxt;
  rirq_flags_a_t events_a;
  rirq_flags_b_t events_b;
  logic          hi_level_r;
  logic          lo_level_r;

  rirq_byte_t    enable_a_r;
  rirq_byte_t    enable_a_nxt;
  rirq_byte_t    enable_b_r;
  rirq_byte_t    enable_b_nxt;

  logic          combined_r;
  logic          combined_nxt;

  rirq_byte_t    rdata_r;
  rirq_byte_t    rdata_nxt;
  logic          rvalid_r;
  logic          rvalid_nxt;

  assign wr_sel  = rirq_decode(reg_addr_i);
  assign rd_sel  = wr_sel;
  assign sel_set = reg_wdata_i[`RIRQ_BIT_SELECT];

  // Event collection; alerts are edge triggered so a standing level cannot re-arm a cleared flag
  always_comb begin
    events_a = '0;
    events_a[`RIRQ_BIT_HI_ALERT] = fifo_hi_level_i & ~hi_level_r;
    events_a[`RIRQ_BIT_LO_ALERT] = fifo_lo_level_i & ~lo_level_r;
    events_a[`RIRQ_BIT_CMD_DONE] = cmd_self_end_i | cmd_unknown_i;
    events_a[`RIRQ_BIT_TX_DONE]  = tx_done_i;
    events_a[`RIRQ_BIT_RX_DONE]  = rx_end_i;
    events_a[`RIRQ_BIT_ERROR]    = error_i;
    events_a[`RIRQ_BIT_FRAME]    = frame_start_i;
    events_b = '0;
    events_b[`RIRQ_BIT_CARD] = card_found_i;
    events_b[`RIRQ_BIT_TIMER_TOP:0] = timer_underflow_i;
  end

  // Flag update: software set or clear first, hardware events OR in last so a set wins
  always_comb begin
    flags_a_nxt = flags_a_r;
    flags_b_nxt = flags_b_r;
    if (reg_wr_i && wr_sel == RIRQ_SEL_FLAGS_A) begin
      if (sel_set) begin
        flags_a_nxt = flags_a_r | reg_wdata_i[6:0];
      end else begin
        flags_a_nxt = flags_a_r & ~reg_wdata_i[6:0];
      end
    end
    if (reg_wr_i && wr_sel == RIRQ_SEL_FLAGS_B) begin
      if (sel_set) begin
        flags_b_nxt = flags_b_r | reg_wdata_i[5:0];
      end else begin
        flags_b_nxt = flags_b_r & ~reg_wdata_i[5:0];
      end
    end
    flags_a_nxt = flags_a_nxt | events_a;
    flags_b_nxt = flags_b_nxt | events_b;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_a_r  <= `RIRQ_RST_FLAGS_A;
      flags_b_r  <= `RIRQ_RST_FLAGS_B;
      hi_level_r <= 1'b0;
      lo_level_r <= 1'b0;
    end else begin
      flags_a_r  <= flags_a_nxt;
      flags_b_r  <= flags_b_nxt;
      hi_level_r <= fifo_hi_level_i;
      lo_level_r <= fifo_lo_level_i;
    end
  end

  // Enable registers
  always_comb begin
    enable_a_nxt = enable_a_r;
    enable_b_nxt = enable_b_r;
    if (reg_wr_i && wr_sel == RIRQ_SEL_ENABLE_A) begin
      enable_a_nxt = reg_wdata_i;
    end
    if (reg_wr_i && wr_sel == RIRQ_SEL_ENABLE_B) begin
      enable_b_nxt = reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enable_a_r <= `RIRQ_RST_ENABLE_A;
      enable_b_r <= `RIRQ_RST_ENABLE_B;
    end else begin
      enable_a_r <= enable_a_nxt;
      enable_b_r <= enable_b_nxt;
    end
  end

  // Combined request, one cycle behind the flags it summarises
  always_comb begin
    combined_nxt = rirq_any_enabled(flags_a_r, flags_b_r, enable_a_r, enable_b_r);
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      combined_r <= 1'b0;
    end else begin
      combined_r <= combined_nxt;
    end
  end

  // Read port; select bits read back as zero since they are write-only
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = reg_rd_i;
    if (reg_rd_i) begin
      if (rd_sel == RIRQ_SEL_FLAGS_A) begin
        rdata_nxt = {1'b0, flags_a_r};
      end else if (rd_sel == RIRQ_SEL_FLAGS_B) begin
        rdata_nxt = {1'b0, combined_r, flags_b_r};
      end else if (rd_sel == RIRQ_SEL_ENABLE_A) begin
        rdata_nxt = enable_a_r;
      end else if (rd_sel == RIRQ_SEL_ENABLE_B) begin
        rdata_nxt = enable_b_r;
      end else begin
        rdata_nxt = `RIRQ_RST_RDATA;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r  <= `RIRQ_RST_RDATA;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_o  = rdata_r;
  assign reg_rvalid_o = rvalid_r;

  rirq_pin_if pin_ctl ();

  assign pin_ctl.req       = combined_r;
  assign pin_ctl.gate      = enable_b_r[`RIRQ_BIT_PIN_GATE];
  assign pin_ctl.invert    = enable_a_r[`RIRQ_BIT_POL_INV];
  assign pin_ctl.push_pull = enable_b_r[`RIRQ_BIT_PUSH_PULL];

  rirq_pin_drv u_pin_drv (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .ctl        (pin_ctl),
    .pin_out_o  (irq_pin_o),
    .pin_oe_o   (irq_pin_oe_o)
  );

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  logic wr_b;
  logic wr_a;
  logic rd_b;
  logic any_a_on;
  logic any_b_on;
  assign wr_b     = reg_wr_i && wr_sel == RIRQ_SEL_FLAGS_B;
  assign wr_a     = reg_wr_i && wr_sel == RIRQ_SEL_FLAGS_A;
  assign rd_b     = reg_rd_i && rd_sel == RIRQ_SEL_FLAGS_B;
  // Spelled out again so the checks do not lean on the function they guard
  assign any_a_on = |(flags_a_r & enable_a_r[6:0]);
  assign any_b_on = |(flags_b_r & enable_b_r[5:0]);

  // Software set and clear of the flag registers
  a_set_flags_b: assert property (wr_b && sel_set
                                  |=> (flags_b_r & $past(reg_wdata_i[5:0])) ==
                                      $past(reg_wdata_i[5:0]))
    else $error("Set write did not set flags b");
  a_clear_flags_b: assert property (wr_b && !sel_set && events_b == '0
                                    |=> (flags_b_r & $past(reg_wdata_i[5:0])) == '0)
    else $error("Clear write did not clear flags b");
  a_keep_flags_b: assert property (wr_b && events_b == '0
                                   |=> (flags_b_r & ~$past(reg_wdata_i[5:0])) ==
                                       ($past(flags_b_r) & ~$past(reg_wdata_i[5:0])))
    else $error("Unselected flag b bits changed");
  a_set_flags_a: assert property (wr_a && reg_wdata_i == 8'hff |=> flags_a_r == 7'h7f)
    else $error("Set all write did not set flags a");
  a_clear_flags_a: assert property (wr_a && reg_wdata_i == 8'h7f && events_a == '0
                                    |=> flags_a_r == 7'h00)
    else $error("Clear all write did not clear flags a");

  // Combined request and the enables behind it
  a_combined_cause: assert property (combined_r |-> $past(any_a_on) || $past(any_b_on))
    else $error("Combined request without enabled flag");
  a_combined_drop: assert property (!any_a_on && !any_b_on |=> !combined_r)
    else $error("Combined request stuck with no enabled flag");
  a_combined_rise: assert property (any_a_on |=> combined_r)
    else $error("Enabled flag a did not raise combined request");
  a_gate_b: assert property (any_b_on |=> combined_r)
    else $error("Enabled flag b did not raise combined request");
  a_enable_a_write: assert property (reg_wr_i && wr_sel == RIRQ_SEL_ENABLE_A
                                     |=> enable_a_r == $past(reg_wdata_i))
    else $error("Enable a write did not land");
  a_enable_b_write: assert property (reg_wr_i && wr_sel == RIRQ_SEL_ENABLE_B
                                     |=> enable_b_r == $past(reg_wdata_i))
    else $error("Enable b write did not land");
  a_read_comb: assert property (rd_b |=> reg_rdata_o[7:6] == {1'b0, $past(combined_r)})
    else $error("Read of flags b shows wrong top bits");

  // Event capture
  a_card_flag: assert property (card_found_i |=> flags_b_r[`RIRQ_BIT_CARD])
    else $error("Card found did not set flag");
  a_timer_flag: assert property (|timer_underflow_i
                                 |=> (flags_b_r[4:0] & $past(timer_underflow_i)) ==
                                     $past(timer_underflow_i))
    else $error("Timer underflow did not set flag");
  a_set_wins: assert property (wr_b && !sel_set && timer_underflow_i[0]
                               |=> flags_b_r[0])
    else $error("Clear write beat a timer underflow");
  a_done_flag: assert property (cmd_self_end_i || cmd_unknown_i
                                |=> flags_a_r[`RIRQ_BIT_CMD_DONE])
    else $error("Command end did not set done flag");
  a_alert_hold: assert property (flags_a_r[`RIRQ_BIT_HI_ALERT] &&
                                 !(wr_a && !sel_set && reg_wdata_i[`RIRQ_BIT_HI_ALERT])
                                 |=> flags_a_r[`RIRQ_BIT_HI_ALERT])
    else $error("High alert flag dropped without clear");
  a_alert_latch: assert property ($rose(fifo_lo_level_i)
                                  |=> flags_a_r[`RIRQ_BIT_LO_ALERT])
    else $error("Low alert rise not latched");

  // The pin register takes the controls of this cycle, so no stability guard is needed
  a_pin_follow: assert property (enable_b_r[7:6] == 2'b11 && !enable_a_r[7]
                                 |=> irq_pin_o == $past(combined_r))
    else $error("Pin does not follow combined request");

  c_set_flags_b: cover property (wr_b && sel_set);
  c_clear_race: cover property (wr_b && !sel_set && |(events_b & reg_wdata_i[5:0]));
  c_pin_active: cover property (combined_r && enable_b_r[`RIRQ_BIT_PIN_GATE]);
  c_open_drain: cover property (irq_pin_oe_o && !enable_b_r[`RIRQ_BIT_PUSH_PULL]);
  c_pin_inverted: cover property (enable_a_r[`RIRQ_BIT_POL_INV] && irq_pin_oe_o);
endmodule

// ===== tb/reader_interrupt_request_logic_test.sv
module reader_interrupt_request_logic_test
  import rirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        arst_n;
  rirq_byte_t  addr;
  rirq_byte_t  wdata;
  logic        wr;
  logic        rd;
  rirq_byte_t  rdata;
  logic        rvalid;
  logic [13:0] ev;
  logic        pin;
  logic        pin_oe;
  logic        level;
  logic        exp_lvl;
  int          num_errors = 0;
  int          checked = 0;

  rirq_top u_dut (
    .core_clk_i        (core_clk),
    .arst_n_i          (arst_n),
    .reg_addr_i        (addr),
    .reg_wdata_i       (wdata),
    .reg_wr_i          (wr),
    .reg_rd_i          (rd),
    .reg_rdata_o       (rdata),
    .reg_rvalid_o      (rvalid),
    .fifo_hi_level_i   (ev[7]),
    .fifo_lo_level_i   (ev[6]),
    .cmd_self_end_i    (ev[4]),
    .cmd_unknown_i     (ev[5]),
    .tx_done_i         (ev[3]),
    .rx_end_i          (ev[2]),
    .error_i           (ev[1]),
    .frame_start_i     (ev[0]),
    .card_found_i      (ev[13]),
    .timer_underflow_i (ev[12:8]),
    .irq_pin_o         (pin),
    .irq_pin_oe_o      (pin_oe)
  );

  rirq_host_model u_host (
    .irq_pin_i    (pin),
    .irq_pin_oe_i (pin_oe),
    .irq_level_o  (level)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input rirq_byte_t seen, input rirq_byte_t exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each access leaves one idle edge so a strobe is never re-raised in the same step
  task automatic wr_reg(input rirq_byte_t a, input rirq_byte_t d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge core_clk);
    #2;
    wr = 1'b0;
    @(posedge core_clk);
    #2;
  endtask

  task automatic rd_chk(input rirq_byte_t a, input rirq_byte_t exp);
    addr = a;
    rd = 1'b1;
    @(posedge core_clk);
    #2;
    rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
    @(posedge core_clk);
    #2;
  endtask

  task automatic pulse(input int i);
    ev[i] = 1'b1;
    @(posedge core_clk);
    #2;
    ev[i] = 1'b0;
    @(posedge core_clk);
    #2;
  endtask

  initial begin
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ev = '0;
    repeat (3) @(posedge core_clk);
    #2;
    arst_n = 1'b1;
    @(posedge core_clk);
    #2;
    // Reset values, unmapped 0x0a included
    for (int a = 6; a <= 10; a++) rd_chk(8'(a), 8'h00);
    check({6'h00, pin_oe, pin}, 8'h02);
    wr_reg(8'h08, 8'h5a);
    rd_chk(8'h08, 8'h5a);
    wr_reg(8'h09, 8'ha5);
    rd_chk(8'h09, 8'ha5);
    wr_reg(8'h08, 8'h00);
    wr_reg(8'h09, 8'h00);
    wr_reg(8'h07, 8'hbf);
    rd_chk(8'h07, 8'h3f);
    wr_reg(8'h07, 8'h15);
    rd_chk(8'h07, 8'h2a);
    wr_reg(8'h07, 8'h3f);
    rd_chk(8'h07, 8'h00);
    wr_reg(8'h06, 8'hff);
    rd_chk(8'h06, 8'h7f);
    wr_reg(8'h06, 8'h2a);
    rd_chk(8'h06, 8'h55);
    wr_reg(8'h06, 8'h7f);
    rd_chk(8'h06, 8'h00);
    // Every event source lands in its flag; both command-end sources share the command-done flag
    for (int i = 0; i < 14; i++) begin
      pulse(i);
      if (i < 8) rd_chk(8'h06, 8'h01 << ((i < 4) ? i : (i < 6) ? 4 : i - 1));
      else rd_chk(8'h07, 8'h01 << (i - 8));
      wr_reg(8'h06, 8'h7f);
      wr_reg(8'h07, 8'h3f);
    end
    // A level held high must not re-latch after a clear
    ev[7] = 1'b1;
    @(posedge core_clk);
    #2;
    rd_chk(8'h06, 8'h40);
    wr_reg(8'h06, 8'h40);
    rd_chk(8'h06, 8'h00);
    ev[7] = 1'b0;
    // Only the matching enable bit lets a flag reach the combined request
    for (int g = 0; g < 2; g++) begin
      for (int b = 0; b < 7 - g; b++) begin
        wr_reg(8'(6 + g), 8'h80 | (8'h01 << b));
        wr_reg(8'(8 + g), ~(8'h01 << b) & (g ? 8'h3f : 8'h7f));
        rd_chk(8'h07, g ? (8'h01 << b) : 8'h00);
        wr_reg(8'(8 + g), 8'h01 << b);
        rd_chk(8'h07, 8'h40 | (g ? (8'h01 << b) : 8'h00));
        wr_reg(8'(6 + g), g ? 8'h3f : 8'h7f);
        rd_chk(8'h07, 8'h00);
        wr_reg(8'(8 + g), 8'h00);
      end
    end
    // Every mix of drive mode, pin gate, polarity and request
    wr_reg(8'h07, 8'h81);
    for (int m = 0; m < 16; m++) begin
      wr_reg(8'h08, {m[2], 7'h00});
      wr_reg(8'h09, {m[0], m[1], 5'h00, m[3]});
      repeat (3) @(posedge core_clk);
      #2;
      exp_lvl = (m[3] & m[1]) ^ m[2];
      check({7'h00, level}, {7'h00, exp_lvl});
      check({6'h00, pin_oe, pin}, {6'h00, m[0] | !exp_lvl, m[0] & exp_lvl});
    end
    // A clear meeting an underflow in the same cycle loses to it
    addr  = 8'h07;
    wdata = 8'h01;
    wr    = 1'b1;
    ev[8] = 1'b1;
    @(posedge core_clk);
    #2;
    wr    = 1'b0;
    ev[8] = 1'b0;
    @(posedge core_clk);
    #2;
    rd_chk(8'h07, 8'h41);
    // Event to pin takes exactly three edges
    wr_reg(8'h07, 8'h3f);
    wr_reg(8'h08, 8'h00);
    wr_reg(8'h09, 8'hc1);
    ev[8] = 1'b1;
    @(posedge core_clk);
    #2;
    ev[8] = 1'b0;
    @(posedge core_clk);
    #2;
    check({7'h00, pin}, 8'h00);
    @(posedge core_clk);
    #2;
    check({7'h00, pin}, 8'h01);
    results;
  end

  initial begin
    #200000;
    num_errors++;
    results;
  end
endmodule

// ===== tb/rirq_host_model.sv
module rirq_host_model (
  input  wire logic irq_pin_i,
  input  wire logic irq_pin_oe_i,
  output logic      irq_level_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Host side has a pull-up, so a released pin reads high rather than a stale value
  assign irq_level_o = irq_pin_oe_i ? irq_pin_i : 1'b1;
endmodule
